/* File: rtl/erw_bus_ctrl.sv */
// Function
// R1 - Ready inactive: add wait state, resample
// R2 - Ready active ends cycle, polarity selectable
// R3 - Programmed wait states run before sampling
// R4 - Strobe leading edge follows read/write delay
// R5 - Partner may drop ready after strobe
// R6 - Unaligned async ready held two half-periods
// R7 - Synchronous and asynchronous ready modes supported
// R8 - Mux wait after mux cycle, optional tristate
// R9 - Gap two bus clocks mux+tristate, demux zero; code gives demux with tristate a one bus clock gap
// R10 - Bus clock period two half-periods
// R11 - Demux then mux inserts two half-periods idle
// R12 - Ready disabled: end after programmed waits
`timescale 1ns/10ps
`default_nettype none
module erw_bus_ctrl
	import erw_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Bus cycle requests
	input  wire logic        cycle_req,
	input  wire logic        cycle_write,
	output logic             cycle_busy,
	output logic             cycle_done,
	// External bus pins
	input  wire logic        ready_pin,
	output logic             rd_strobe_n,
	output logic             wr_strobe_n,
	output logic             bus_clock_output
);
	logic [ERW_CTRL_W-1:0] ctrl_q;
	erw_state_t            state_q;
	logic                  phase_q;
	logic                  pend_q;
	logic                  write_q;
	logic                  first_q;
	logic                  prev_demux_q;
	logic [ERW_WAIT_W-1:0] wcnt_q;
	logic [7:0]            rwait_q;
	logic [7:0]            last_rwait_q;
	logic [CNT_W-1:0]      count_q;
	logic                  tick;
	logic                  cmd_end;
	logic                  finish;
	logic                  strobe_on;
	erw_rdy_if             rdy ();

	// Control fields
	logic [ERW_WAIT_W-1:0] cfg_wait;
	logic                  cfg_rwdly;
	logic                  cfg_mux;
	logic                  cfg_tri;
	logic                  cfg_rdyen;

	assign cfg_wait  = ctrl_q[ERW_WAIT_LSB +: ERW_WAIT_W];
	assign cfg_rwdly = ctrl_q[ERW_RWDLY_BIT];
	assign cfg_mux   = ctrl_q[ERW_MUX_BIT];
	assign cfg_tri   = ctrl_q[ERW_TRI_BIT];
	assign cfg_rdyen = ctrl_q[ERW_RDYEN_BIT];
	assign rdy.async_mode  = ctrl_q[ERW_ASYNC_BIT];
	assign rdy.active_high = ctrl_q[ERW_RDYHI_BIT];

	// Ready pin synchroniser
	erw_ready_sync u_sync (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ready_pin (ready_pin),
		.rdy       (rdy.sync)
	);

	// Half-period phase; sequencer steps once per bus clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q; // R10
		end
	end
	assign tick = phase_q;
	assign bus_clock_output = phase_q; // R10

	// Command phase ends on expired waits and ready, or waits alone
	always_comb begin
		cmd_end = 1'b0;
		if (state_q == ERW_CMD && wcnt_q == '0) begin // R3
			if (!cfg_rdyen) begin
				cmd_end = 1'b1; // R12
			end else begin
				cmd_end = rdy.ready_seen; // R2
			end
		end
	end

	// Cycle is complete when the command state, or the last trailing state if any, is left
	always_comb begin
		finish = 1'b0;
		if (tick) begin
			unique case (state_q)
				ERW_CMD:  finish = cmd_end && !cfg_mux && !cfg_tri; // R9
				ERW_MUXW: finish = !cfg_tri;
				ERW_TRIW: finish = 1'b1;
				default:  finish = 1'b0;
			endcase
		end
	end

	// Control register write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= ERW_CTRL_RST;
		end else if (reg_wr && reg_addr == ERW_CTRL_OFS) begin
			ctrl_q <= reg_wdata[ERW_CTRL_W-1:0];
		end
	end

	// Request capture; ignored while busy
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_q  <= 1'b0;
			write_q <= 1'b0;
		end else if (cycle_req && !cycle_busy) begin
			pend_q  <= 1'b1;
			write_q <= cycle_write;
		end else if (tick && state_q == ERW_IDLE) begin
			pend_q  <= 1'b0;
		end
	end
	assign cycle_busy = pend_q || (state_q != ERW_IDLE);

	// Bus cycle sequencer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ERW_IDLE;
		end else if (tick) begin
			unique case (state_q)
				ERW_IDLE: begin
					if (pend_q) begin
						state_q <= (cfg_mux && prev_demux_q) ?
							ERW_SWITCH : ERW_ADDR; // R11
					end
				end
				ERW_SWITCH: state_q <= ERW_ADDR; // R11
				ERW_ADDR:   state_q <= ERW_CMD;
				ERW_CMD: begin
					if (cmd_end) begin
						if (cfg_mux) begin
							state_q <= ERW_MUXW; // R8
						end else if (cfg_tri) begin
							state_q <= ERW_TRIW; // R8
						end else begin
							state_q <= ERW_IDLE;
						end
					end
				end
				ERW_MUXW: state_q <= cfg_tri ? ERW_TRIW : ERW_IDLE; // R8
				ERW_TRIW: state_q <= ERW_IDLE;
				default:  state_q <= ERW_IDLE;
			endcase
		end
	end

	// Memory-cycle wait counter and ready wait counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wcnt_q  <= '0;
			rwait_q <= 8'h00;
		end else if (tick && state_q == ERW_ADDR) begin
			wcnt_q  <= cfg_wait; // R3
			rwait_q <= 8'h00;
		end else if (tick && state_q == ERW_CMD) begin
			if (wcnt_q != '0) begin
				wcnt_q <= wcnt_q - 1'b1; // R3
			end else if (!cmd_end && rwait_q != 8'hff) begin
				rwait_q <= rwait_q + 8'h01; // R1
			end
		end
	end

	// First command cycle flag for the delayed strobe edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			first_q <= 1'b0;
		end else if (tick) begin
			first_q <= (state_q == ERW_ADDR);
		end
	end

	// Remember a finished demux cycle for the switch idle state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_demux_q <= 1'b0;
		end else if (tick && state_q == ERW_CMD && cmd_end) begin
			prev_demux_q <= !cfg_mux; // R11
		end
	end

	// Completion statistics
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q      <= '0;
			last_rwait_q <= 8'h00;
		end else if (finish) begin
			count_q      <= count_q + 1'b1;
			last_rwait_q <= rwait_q;
		end
	end
	assign cycle_done = finish;

	// Strobe: delayed by one half-period in the first cycle
	always_comb begin
		strobe_on = (state_q == ERW_CMD) &&
			!(cfg_rwdly && first_q && !phase_q); // R4
		rd_strobe_n = ~(strobe_on && !write_q);
		wr_strobe_n = ~(strobe_on && write_q);
	end

	// Register read, data in the cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ERW_CTRL_OFS:   reg_rdata <= 32'(ctrl_q);
				ERW_STATUS_OFS: reg_rdata <= {16'h0000, last_rwait_q,
					1'b0, pend_q, state_q};
				ERW_COUNT_OFS:  reg_rdata <= 32'(count_q);
				default:        reg_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : erw_bus_ctrl
`default_nettype wire

/* File: include/erw_pkg.sv */
`default_nettype none
package erw_pkg;
	// Register word offsets (byte addresses)
	localparam logic [7:0] ERW_CTRL_OFS   = 8'h00;
	localparam logic [7:0] ERW_STATUS_OFS = 8'h04;
	localparam logic [7:0] ERW_COUNT_OFS  = 8'h08;

	// Control field positions
	localparam int ERW_WAIT_LSB  = 0;
	localparam int ERW_WAIT_W    = 4;
	localparam int ERW_RWDLY_BIT = 4;
	localparam int ERW_MUX_BIT   = 5;
	localparam int ERW_TRI_BIT   = 6;
	localparam int ERW_RDYEN_BIT = 7;
	localparam int ERW_ASYNC_BIT = 8;
	localparam int ERW_RDYHI_BIT = 9;
	localparam int ERW_CTRL_W    = 10;

	// Control value after reset: demux, no waits, ready off
	localparam logic [ERW_CTRL_W-1:0] ERW_CTRL_RST = 10'h000;

	// Bus clock timing: one half period is one clk cycle
	localparam int ERW_CLK_NS      = 20;
	localparam int ERW_HALF_NS     = 20;
	localparam int ERW_HALF_CYCLES =
		(ERW_HALF_NS + ERW_CLK_NS - 1) / ERW_CLK_NS;

	// Bus cycle sequencer states
	typedef enum logic [5:0] {
		ERW_IDLE   = 6'b000001,
		ERW_SWITCH = 6'b000010,
		ERW_ADDR   = 6'b000100,
		ERW_CMD    = 6'b001000,
		ERW_MUXW   = 6'b010000,
		ERW_TRIW   = 6'b100000
	} erw_state_t;
endpackage : erw_pkg
`default_nettype wire

/* File: include/erw_rdy_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface erw_rdy_if;
	logic async_mode;
	logic active_high;
	logic ready_seen;

	// Sequencer side sets the mode, reads the qualified ready
	modport ctrl (output async_mode, output active_high, input ready_seen);
	// Synchroniser side
	modport sync (input async_mode, input active_high, output ready_seen);
endinterface : erw_rdy_if
`default_nettype wire

/* File: rtl/erw_ready_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module erw_ready_sync
	import erw_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Ready pin and qualified result
	input  wire logic ready_pin,
	erw_rdy_if.sync   rdy
);
	logic meta_q;
	logic sync_q;
	logic late_q;
	logic level;

	// Two-stage pin synchroniser, plus one stage for asynchronous mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			late_q <= 1'b0;
		end else begin
			meta_q <= ready_pin;
			sync_q <= meta_q;
			late_q <= sync_q;
		end
	end

	// Mode picks the sampling path, polarity picks the active level
	always_comb begin
		level = rdy.async_mode ? late_q : sync_q; // R7
		rdy.ready_seen = rdy.active_high ? level : ~level; // R2
	end
endmodule : erw_ready_sync
`default_nettype wire

/* File: testbench/erw_ready_model.sv */
`timescale 1ns/10ps
`default_nettype none
module erw_ready_model (
	// Bus side
	input  wire logic       clk,
	input  wire logic       rd_strobe_n,
	input  wire logic       wr_strobe_n,
	// Behaviour knobs
	input  wire logic       act_hi,
	input  wire logic [3:0] delay,
	output logic            ready_pin
);
	logic [3:0] cnt_q;
	logic       rdy;
	// Counts strobe cycles, restarts once the strobe is released
	always_ff @(posedge clk) begin
		if (rd_strobe_n && wr_strobe_n) begin
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'hf) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	// Ready stays up until the strobe rises, then drops
	assign rdy = !(rd_strobe_n && wr_strobe_n) && cnt_q >= delay;
	assign ready_pin = act_hi ? rdy : !rdy;
endmodule : erw_ready_model
`default_nettype wire

/* File: testbench/erw_bus_ctrl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module erw_bus_ctrl_chk (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Cycle handshake and pins
	input  wire logic cycle_req,
	input  wire logic cycle_busy,
	input  wire logic cycle_done,
	input  wire logic rd_strobe_n,
	input  wire logic wr_strobe_n,
	input  wire logic bus_clock_output
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Request accepted and the quiet start that follows
	sequence s_taken;
		cycle_req && !cycle_busy;
	endsequence
	sequence s_quiet;
		!cycle_done [*3];
	endsequence
	clk_toggle_a: assert property (!$past(sys_rst) |-> $changed(bus_clock_output))
		else $error("bus clock did not toggle");
	min_len_a: assert property (s_taken |=> s_quiet)
		else $error("cycle ended too early");
	req_busy_a: assert property (s_taken |=> cycle_busy)
		else $error("request not taken");
	done_pulse_a: assert property (cycle_done |=> !cycle_done)
		else $error("done longer than one cycle");
	done_idle_a: assert property (cycle_done |=> !cycle_busy)
		else $error("busy after done");
	done_strobe_a: assert property (cycle_done |=> rd_strobe_n && wr_strobe_n)
		else $error("strobe after done");
	strobe_excl_a: assert property (rd_strobe_n || wr_strobe_n)
		else $error("both strobes low");
	strobe_busy_a: assert property (!(rd_strobe_n && wr_strobe_n) |-> cycle_busy)
		else $error("strobe outside a cycle");
endmodule : erw_bus_ctrl_chk
bind erw_bus_ctrl erw_bus_ctrl_chk u_chk (.clk(clk), .sys_rst(sys_rst),
	.cycle_req(cycle_req), .cycle_busy(cycle_busy), .cycle_done(cycle_done),
	.rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
	.bus_clock_output(bus_clock_output));
`default_nettype wire

/* File: testbench/test_ext_bus_ready_waitstate.sv */
`timescale 1ns/10ps
`default_nettype none
module test_ext_bus_ready_waitstate;
	import erw_pkg::*;
	logic        clk, sys_rst, reg_wr, reg_rd, cycle_req, cycle_write;
	logic        cycle_busy, cycle_done, ready_pin, rd_strobe_n, wr_strobe_n;
	logic        bus_clock_output, act_hi, mux, tw, dly;
	logic [7:0]  reg_addr;
	logic [3:0]  delay, w;
	logic [31:0] reg_wdata, reg_rdata, ctrl, d;
	int          bad_count, n_tests, base, len, cyc, k, ncyc, ns, rwx;
	// Plain demux read, no waits: request edge to done, in clocks
	localparam int BASE_LEN = 5;

	erw_bus_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cycle_req(cycle_req),
		.cycle_write(cycle_write), .cycle_busy(cycle_busy),
		.cycle_done(cycle_done), .ready_pin(ready_pin),
		.rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
		.bus_clock_output(bus_clock_output));
	erw_ready_model u_mem (.clk(clk), .rd_strobe_n(rd_strobe_n),
		.wr_strobe_n(wr_strobe_n), .act_hi(act_hi), .delay(delay),
		.ready_pin(ready_pin));

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cuts a hung run short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd

	// One bus cycle, started on a fixed bus clock phase, length in clocks
	task automatic run(input logic wrt, output int n, output int ns);
		logic sr, sw;
		sr = 1'b0;
		sw = 1'b0;
		n = 0;
		ns = 0;
		do @(negedge clk); while (bus_clock_output !== 1'b1);
		@(posedge clk);
		cycle_req <= 1'b1;
		cycle_write <= wrt;
		@(posedge clk);
		cycle_req <= 1'b0;
		do begin
			@(negedge clk);
			n++;
			sr |= !rd_strobe_n;
			sw |= !wr_strobe_n;
			ns += int'(!rd_strobe_n || !wr_strobe_n);
		end while (cycle_done !== 1'b1);
		@(posedge clk);
		ncyc++;
		chk(32'({sr, sw}), 32'({!wrt, wrt}));
	endtask : run

	task automatic final_report();
		$display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, cycle_req, cycle_write, act_hi} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		delay = 4'hf;
		k = $urandom(32'ha5a2);
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		run(1'b0, base, ns);
		chk(32'(base), 32'(BASE_LEN));
		chk(32'(ns), 32'h2);
		// Waits, mux wait, tristate wait, switch idle; ready ignored
		for (k = 0; k < 4; k++) begin
			w = 4'($urandom);
			mux = (k == 1 || k == 2);
			tw = (k >= 2);
			dly = 1'($urandom);
			ctrl = {25'h0, tw, mux, dly, w};
			wr(ERW_CTRL_OFS, ctrl);
			rd(ERW_CTRL_OFS, d);
			chk(d, ctrl);
			run(1'($urandom), len, ns);
			chk(32'(len), 32'(BASE_LEN + 2 * (w + mux + tw + (k == 1))));
			// Strobe spans the command bus clocks, less one half if delayed
			chk(32'(ns), 32'(2 * (w + 1) - dly));
		end
		// Slow ready in both polarities and both sampling modes
		delay <= 4'h3;
		for (k = 0; k < 4; k++) begin
			act_hi <= k[0];
			ctrl = {22'h0, k[0], k[1], 1'b1, 7'h00};
			wr(ERW_CTRL_OFS, ctrl);
			run(k[1], len, ns);
			rd(ERW_STATUS_OFS, d);
			// Ready seen after model delay plus two or three sync stages
			rwx = (int'(delay) + 2 + k[1]) / 2;
			chk(32'(d[15:8]), 32'(rwx));
			chk(32'(len), 32'(BASE_LEN + 2 * rwx));
			chk(32'(ns), 32'(2 * (rwx + 1)));
		end
		// Unmapped read, ignored write to the counter
		rd(8'h0c, d);
		chk(d, 32'h0);
		wr(ERW_COUNT_OFS, 32'hffffffff);
		rd(ERW_COUNT_OFS, d);
		chk(d, 32'(ncyc));
		final_report();
	end
endmodule : test_ext_bus_ready_waitstate
`default_nettype wire
